// [hdl/iefr_defines.svh]
// Offsets, bit positions, reset values and rules of the interrupt registers.
`ifndef IEFR_DEFINES_SVH
`define IEFR_DEFINES_SVH

`define IEFR_OFF_EDGE    8'h00
`define IEFR_OFF_CTRL_A  8'h04
`define IEFR_OFF_CTRL_B  8'h08
`define IEFR_OFF_GROUP_A 8'h0C
`define IEFR_OFF_GROUP_B 8'h10

`define IEFR_MASK_EDGE    8'h03
`define IEFR_MASK_CTRL_A  8'h7F
`define IEFR_MASK_CTRL_B  8'hBB
`define IEFR_MASK_GROUP   8'h33

`define IEFR_RESET_VALUE  8'h00

`define IEFR_BIT_GIE      0
`define IEFR_BIT_PIN_EN   1
`define IEFR_BIT_TBA_EN   2
`define IEFR_BIT_TBB_EN   3
`define IEFR_BIT_PIN_FLAG 4
`define IEFR_BIT_TBA_FLAG 5
`define IEFR_BIT_TBB_FLAG 6

`define IEFR_BIT_GRPA_EN   0
`define IEFR_BIT_EE_EN     1
`define IEFR_BIT_GRPB_EN   3
`define IEFR_BIT_GRPA_FLAG 4
`define IEFR_BIT_EE_FLAG   5
`define IEFR_BIT_GRPB_FLAG 7

`define IEFR_BIT_CMP_P_EN   0
`define IEFR_BIT_CMP_A_EN   1
`define IEFR_BIT_CMP_P_FLAG 4
`define IEFR_BIT_CMP_A_FLAG 5

`define IEFR_AXI_OKAY   2'b00
`define IEFR_AXI_SLVERR 2'b10

`endif

// [hdl/iefr_group_reg.sv]
// One grouped timer register: two compare flags with their enables.
`timescale 1ns/1ps
`include "iefr_defines.svh"
module iefr_group_reg
  import iefr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       writeEn,
  input  wire logic [7:0] writeData,
  input  wire logic       cmpPEvent,
  input  wire logic       cmpAEvent,
  output logic [7:0]      regValue,
  output logic            groupRequest,
  output logic            flagRise
);
  logic [7:0] next_regValue;

  always_comb
  begin
    next_regValue = regValue;
    if (writeEn)
      next_regValue = writeData & `IEFR_MASK_GROUP;
    // Hardware set wins over a software clear in the same cycle.
    if (cmpPEvent)
      next_regValue[`IEFR_BIT_CMP_P_FLAG] = 1'b1;
    if (cmpAEvent)
      next_regValue[`IEFR_BIT_CMP_A_FLAG] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      regValue <= `IEFR_RESET_VALUE;
    else
      regValue <= next_regValue;
  end

  assign groupRequest =
    (regValue[`IEFR_BIT_CMP_P_FLAG] & regValue[`IEFR_BIT_CMP_P_EN]) |
    (regValue[`IEFR_BIT_CMP_A_FLAG] & regValue[`IEFR_BIT_CMP_A_EN]);

  assign flagRise =
    (next_regValue[`IEFR_BIT_CMP_P_FLAG] & ~regValue[`IEFR_BIT_CMP_P_FLAG]) |
    (next_regValue[`IEFR_BIT_CMP_A_FLAG] & ~regValue[`IEFR_BIT_CMP_A_FLAG]);
endmodule : iefr_group_reg

// [hdl/iefr_irq_regs.sv]
// Interrupt enable and flag register set with an AXI4-Lite slave port.
`timescale 1ns/1ps
`include "iefr_defines.svh"
module iefr_irq_regs
  import iefr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pinIrqIn,
  input  wire logic        timebaseAEvent,
  input  wire logic        timebaseBEvent,
  input  wire logic        eepromEvent,
  input  wire logic        stdTimerCmpPEvent,
  input  wire logic        stdTimerCmpAEvent,
  input  wire logic        periodicTimerCmpPEvent,
  input  wire logic        periodicTimerCmpAEvent,
  input  wire logic        irqAck,
  output logic             irqRequest,
  output logic [2:0]       irqSource,
  output logic             wakeRequest
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic [7:0] edgeReg;
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;
  logic [7:0] groupA;
  logic [7:0] groupB;
  logic       awHeld;
  logic       wHeld;
  logic [7:0] awAddr;
  logic [7:0] wByte;
  logic       wByteEn;
  logic       wrFire;

  function automatic logic hitReg(input logic [7:0] addr,
                                  input logic [7:0] offset);
    hitReg = (addr[7:2] == offset[7:2]);
  endfunction : hitReg

  function automatic logic mappedAddr(input logic [7:0] addr);
    mappedAddr = hitReg(addr, `IEFR_OFF_EDGE) |
                 hitReg(addr, `IEFR_OFF_CTRL_A) |
                 hitReg(addr, `IEFR_OFF_CTRL_B) |
                 hitReg(addr, `IEFR_OFF_GROUP_A) |
                 hitReg(addr, `IEFR_OFF_GROUP_B);
  endfunction : mappedAddr

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign wrFire        = awHeld & wHeld & ~s_axi_bvalid;

  // Address and data may arrive in either order; both are held here.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddr  <= 8'h00;
      wByte   <= 8'h00;
      wByteEn <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      else if (wrFire)
        awHeld <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld   <= 1'b1;
        wByte   <= s_axi_wdata[7:0];
        wByteEn <= s_axi_wstrb[0];
      end
      else if (wrFire)
        wHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IEFR_AXI_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mappedAddr(awAddr) ? `IEFR_AXI_OKAY : `IEFR_AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  logic wrEdge;
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrGroupA;
  logic wrGroupB;

  assign wrEdge   = wrFire & wByteEn & hitReg(awAddr, `IEFR_OFF_EDGE);
  assign wrCtrlA  = wrFire & wByteEn & hitReg(awAddr, `IEFR_OFF_CTRL_A);
  assign wrCtrlB  = wrFire & wByteEn & hitReg(awAddr, `IEFR_OFF_CTRL_B);
  assign wrGroupA = wrFire & wByteEn & hitReg(awAddr, `IEFR_OFF_GROUP_A);
  assign wrGroupB = wrFire & wByteEn & hitReg(awAddr, `IEFR_OFF_GROUP_B);

  assign s_axi_arready = ~s_axi_rvalid;

  // Reads see all five registers; bits above the byte read as zero.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `IEFR_AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mappedAddr(s_axi_araddr) ? `IEFR_AXI_OKAY
                                               : `IEFR_AXI_SLVERR;
      s_axi_rdata  <= {24'h00_0000,
        ({8{hitReg(s_axi_araddr, `IEFR_OFF_EDGE)}}    & edgeReg) |
        ({8{hitReg(s_axi_araddr, `IEFR_OFF_CTRL_A)}}  & ctrlA)   |
        ({8{hitReg(s_axi_araddr, `IEFR_OFF_CTRL_B)}}  & ctrlB)   |
        ({8{hitReg(s_axi_araddr, `IEFR_OFF_GROUP_A)}} & groupA)  |
        ({8{hitReg(s_axi_araddr, `IEFR_OFF_GROUP_B)}} & groupB)};
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************************
  // Sources
  // ****************************************************************
  logic pinHit;
  logic grpAReq;
  logic grpBReq;
  logic grpARise;
  logic grpBRise;

  iefr_pin_edge u_pin_edge
  (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .pinIn      (pinIrqIn),
    .edgeSelect (edgeReg[1:0]),
    .edgeHit    (pinHit)
  );

  iefr_group_reg u_group_a
  (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .writeEn      (wrGroupA),
    .writeData    (wByte),
    .cmpPEvent    (stdTimerCmpPEvent),
    .cmpAEvent    (stdTimerCmpAEvent),
    .regValue     (groupA),
    .groupRequest (grpAReq),
    .flagRise     (grpARise)
  );

  iefr_group_reg u_group_b
  (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .writeEn      (wrGroupB),
    .writeData    (wByte),
    .cmpPEvent    (periodicTimerCmpPEvent),
    .cmpAEvent    (periodicTimerCmpAEvent),
    .regValue     (groupB),
    .groupRequest (grpBReq),
    .flagRise     (grpBRise)
  );

  // ****************************************************************
  // Edge select and primary registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      edgeReg <= `IEFR_RESET_VALUE;
    else if (wrEdge)
      edgeReg <= wByte & `IEFR_MASK_EDGE;
  end

  logic [7:0] next_ctrlA;
  logic [7:0] next_ctrlB;
  logic       irqTaken;

  assign irqTaken = irqRequest & irqAck;

  // Hardware flag sets are applied after the write, so a set wins.
  always_comb
  begin
    next_ctrlA = ctrlA;
    if (wrCtrlA)
      next_ctrlA = wByte & `IEFR_MASK_CTRL_A;
    if (irqTaken)
      next_ctrlA[`IEFR_BIT_GIE] = 1'b0;
    if (pinHit)
      next_ctrlA[`IEFR_BIT_PIN_FLAG] = 1'b1;
    if (timebaseAEvent)
      next_ctrlA[`IEFR_BIT_TBA_FLAG] = 1'b1;
    if (timebaseBEvent)
      next_ctrlA[`IEFR_BIT_TBB_FLAG] = 1'b1;
  end

  always_comb
  begin
    next_ctrlB = ctrlB;
    if (wrCtrlB)
      next_ctrlB = wByte & `IEFR_MASK_CTRL_B;
    if (eepromEvent)
      next_ctrlB[`IEFR_BIT_EE_FLAG] = 1'b1;
    if (grpAReq)
      next_ctrlB[`IEFR_BIT_GRPA_FLAG] = 1'b1;
    if (grpBReq)
      next_ctrlB[`IEFR_BIT_GRPB_FLAG] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrlA <= `IEFR_RESET_VALUE;
      ctrlB <= `IEFR_RESET_VALUE;
    end
    else
    begin
      ctrlA <= next_ctrlA;
      ctrlB <= next_ctrlB;
    end
  end

  // ****************************************************************
  // Request and wake-up
  // ****************************************************************
  logic pinPend;
  logic tbaPend;
  logic tbbPend;
  logic grpAPend;
  logic grpBPend;
  logic eePend;
  logic flagRiseAny;

  assign pinPend  = ctrlA[`IEFR_BIT_PIN_FLAG] &
                    ctrlA[`IEFR_BIT_PIN_EN];
  assign tbaPend  = ctrlA[`IEFR_BIT_TBA_FLAG] &
                    ctrlA[`IEFR_BIT_TBA_EN];
  assign tbbPend  = ctrlA[`IEFR_BIT_TBB_FLAG] &
                    ctrlA[`IEFR_BIT_TBB_EN];
  assign grpAPend = ctrlB[`IEFR_BIT_GRPA_FLAG] & ctrlB[`IEFR_BIT_GRPA_EN];
  assign grpBPend = ctrlB[`IEFR_BIT_GRPB_FLAG] & ctrlB[`IEFR_BIT_GRPB_EN];
  assign eePend   = ctrlB[`IEFR_BIT_EE_FLAG] &
                    ctrlB[`IEFR_BIT_EE_EN];

  // Fixed priority picks the source the core should vector to.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqRequest <= 1'b0;
      irqSource  <= IEFR_SRC_NONE;
    end
    else
    begin
      irqRequest <= ctrlA[`IEFR_BIT_GIE] & ~irqTaken &
        (pinPend | tbaPend | tbbPend | grpAPend | grpBPend | eePend);
      if (pinPend)
        irqSource <= IEFR_SRC_PIN;
      else if (tbaPend)
        irqSource <= IEFR_SRC_TBA;
      else if (tbbPend)
        irqSource <= IEFR_SRC_TBB;
      else if (grpAPend)
        irqSource <= IEFR_SRC_GRPA;
      else if (grpBPend)
        irqSource <= IEFR_SRC_GRPB;
      else if (eePend)
        irqSource <= IEFR_SRC_EE;
      else
        irqSource <= IEFR_SRC_NONE;
    end
  end

  // Any flag going from 0 to 1 wakes the core, enabled or not, except a ctrlA or ctrlB flag whose bit is already set in the other.
  assign flagRiseAny = |((next_ctrlA | next_ctrlB) & ~(ctrlA | ctrlB) &
                         8'hF0) | grpARise | grpBRise;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      wakeRequest <= 1'b0;
    else
      wakeRequest <= flagRiseAny;
  end
endmodule : iefr_irq_regs

// [hdl/iefr_pin_edge.sv]
// Synchroniser and edge detector for the external interrupt pin.
`timescale 1ns/1ps
module iefr_pin_edge
  import iefr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       pinIn,
  input  wire logic [1:0] edgeSelect,
  output logic            edgeHit
);
  logic syncFirst;
  logic syncSecond;
  logic pinLast;

  // Two flops before any logic reads the pin.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      pinLast    <= 1'b0;
    end
    else
    begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      pinLast    <= syncSecond;
    end
  end

  always_comb
  begin
    case (iefr_edge_t'(edgeSelect))
      IEFR_EDGE_RISE: edgeHit = syncSecond & ~pinLast;
      IEFR_EDGE_FALL: edgeHit = ~syncSecond & pinLast;
      IEFR_EDGE_BOTH: edgeHit = syncSecond ^ pinLast;
      default:        edgeHit = 1'b0;
    endcase
  end
endmodule : iefr_pin_edge

// [hdl/iefr_pkg.sv]
// Types shared by the interrupt register set.
package iefr_pkg;

  typedef enum logic [1:0]
  {
    IEFR_EDGE_OFF,
    IEFR_EDGE_RISE,
    IEFR_EDGE_FALL,
    IEFR_EDGE_BOTH
  } iefr_edge_t;

  typedef enum logic [2:0]
  {
    IEFR_SRC_PIN,
    IEFR_SRC_TBA,
    IEFR_SRC_TBB,
    IEFR_SRC_GRPA,
    IEFR_SRC_GRPB,
    IEFR_SRC_EE,
    IEFR_SRC_NONE
  } iefr_src_t;

endpackage : iefr_pkg

// [verification/iefr_core_model.sv]
// Behavioural core that takes interrupt requests.
`timescale 1ns/1ps
module iefr_core_model
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic irqRequest,
  input wire logic ackOn,
  input wire logic slow,
  output logic     irqAck
);
  logic [2:0] waitCnt;

  // A slow core lets the request stand for a while, as a busy core would.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      waitCnt <= 3'h0;
      irqAck  <= 1'b0;
    end
    else
    begin
      irqAck <= 1'b0;
      if (!(ackOn && irqRequest) || irqAck)
        waitCnt <= 3'h0;
      else if (waitCnt == (slow ? 3'h4 : 3'h0))
        irqAck <= 1'b1;
      else
        waitCnt <= waitCnt + 3'h1;
    end
  end
endmodule : iefr_core_model

// [verification/iefr_irq_chk.sv]
// Port-level checks on the interrupt register set.
`timescale 1ns/1ps
module iefr_irq_chk
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irqAck,
  input wire logic        irqRequest,
  input wire logic        wakeRequest
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_read_upper:
    assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:8]))
      else $error("read data above bit 7");
  a_unmapped_zero:
    assert property (s_axi_rvalid && s_axi_rresp[1] |-> s_axi_rdata == 0)
      else $error("error read carries data");
  a_read_hold:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
  a_write_hold:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp moved");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken during response");
  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
  a_ack_clears:
    assert property (irqAck && irqRequest |-> ##[1:2] !irqRequest)
      else $error("request stays after ack");
  a_reset_quiet:
    assert property ($rose(rstn) |-> !irqRequest && !wakeRequest)
      else $error("request out of reset");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_ack: cover property (irqAck && irqRequest);
endmodule : iefr_irq_chk

bind iefr_irq_regs iefr_irq_chk iefr_irq_chk_inst
(
  .sys_clk(sys_clk),
  .rstn(rstn),
  .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irqAck(irqAck),
  .irqRequest(irqRequest),
  .wakeRequest(wakeRequest)
);

// [verification/testbench.sv]
// Self-checking bench for the interrupt register set.
`timescale 1ns/1ps
module testbench
  import iefr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0000_0000;
  logic [3:0]  wStrb = 4'h1;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0, pin = 1'b0;
  logic        ackOn = 1'b0, slow = 1'b0;
  logic [6:0]  evt = 7'h00;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        irqReq, irqAck, wake;
  logic [1:0]  bResp, rResp, r;
  logic [2:0]  irqSrc;
  logic [31:0] rData, d;
  logic [31:0] seed = 32'h0000_268d;
  logic [7:0]  msk [5] = '{8'h03, 8'h7F, 8'hBB, 8'h33, 8'h33};
  logic [7:0]  fl [3] = '{8'h20, 8'h40, 8'h10};
  logic [7:0]  en [3] = '{8'h04, 8'h08, 8'h02};
  iefr_src_t   sr [3] = '{IEFR_SRC_TBA, IEFR_SRC_TBB, IEFR_SRC_PIN};
  int          mdl [5] = '{0, 0, 0, 0, 0};
  int          failCount = 0, cmpCount = 0, cyc = 0, wakeCnt = 0;
  int          i, k, n, g;

  iefr_irq_regs iefr_irq_regs_inst
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid),
    .s_axi_awready(awReady),
    .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid),
    .s_axi_wready(wReady),
    .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid),
    .s_axi_bready(bReady),
    .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid),
    .s_axi_arready(arReady),
    .s_axi_rdata(rData),
    .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid),
    .s_axi_rready(rReady),
    .pinIrqIn(pin),
    .timebaseAEvent(evt[0]),
    .timebaseBEvent(evt[1]),
    .eepromEvent(evt[2]),
    .stdTimerCmpPEvent(evt[3]),
    .stdTimerCmpAEvent(evt[4]),
    .periodicTimerCmpPEvent(evt[5]),
    .periodicTimerCmpAEvent(evt[6]),
    .irqAck(irqAck),
    .irqRequest(irqReq),
    .irqSource(irqSrc),
    .wakeRequest(wake)
  );

  iefr_core_model iefr_core_model_inst
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .irqRequest(irqReq),
    .ackOn(ackOn),
    .slow(slow),
    .irqAck(irqAck)
  );

  always #50 sys_clk = ~sys_clk;

  always @(negedge sys_clk)
    if (wake)
      wakeCnt++;

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failCount++;
      testDone();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready is judged at the falling edge, where nothing moves before the
  // rising edge that completes the handshake.
  task automatic axWr(input logic [7:0] a, input logic [7:0] v,
                      input logic [3:0] st, output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    @(posedge sys_clk);
    awAddr <= a;
    wData <= {24'h00_0000, v};
    wStrb <= st;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!b)
    begin
      @(negedge sys_clk);
      aw = awValid && awReady;
      w = wValid && wReady;
      b = bValid;
      @(posedge sys_clk);
      if (aw)
        awValid <= 1'b0;
      if (w)
        wValid <= 1'b0;
    end
    bReady <= 1'b1;
    @(negedge sys_clk);
    rs = bResp;
    @(posedge sys_clk);
    bReady <= 1'b0;
  endtask : axWr

  task automatic axRd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
    logic ar, b;
    b = 1'b0;
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    while (!b)
    begin
      @(negedge sys_clk);
      ar = arValid && arReady;
      b = rValid;
      @(posedge sys_clk);
      if (ar)
        arValid <= 1'b0;
    end
    rReady <= 1'b1;
    @(negedge sys_clk);
    v = rData;
    rs = rResp;
    @(posedge sys_clk);
    rReady <= 1'b0;
  endtask : axRd

  task automatic wm(input int j, input logic [7:0] v);
    logic [1:0] rs;
    axWr(8'(j * 4), v, 4'h1, rs);
    mdl[j] = v & msk[j];
    chk(rs, 0);
  endtask : wm

  task automatic rc(input int j);
    logic [31:0] v;
    logic [1:0]  rs;
    axRd(8'(j * 4), v, rs);
    chk(v, mdl[j]);
    chk(rs, 0);
  endtask : rc

  task automatic pulse(input int j);
    @(posedge sys_clk);
    evt[j] <= 1'b1;
    @(posedge sys_clk);
    evt[j] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  task automatic tog();
    @(posedge sys_clk);
    pin <= ~pin;
    repeat (6) @(posedge sys_clk);
  endtask : tog

  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : testDone

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 5; i++)
      rc(i);
    for (n = 0; n < 10; n++)
    begin
      seed = xs(seed);
      i = n % 5;
      wm(i, i > 2 ? seed[7:0] & 8'h0F : seed[7:0]);
      rc(i);
    end
    axWr(8'h14, 8'h5A, 4'h1, r);
    chk(r, 2);
    axRd(8'h14, d, r);
    chk({d[29:0], r}, 2);
    for (i = 0; i < 5; i++)
      wm(i, 0);
    axWr(8'h04, 8'h01, 4'h0, r);
    rc(1);
    for (i = 0; i < 4; i++)
    begin
      wm(0, i);
      for (k = 0; k < 2; k++)
      begin
        wm(1, 0);
        tog();
        mdl[1] = i[k] ? 8'h10 : 8'h00;
        rc(1);
      end
    end
    for (k = 0; k < 3; k++)
    begin
      wm(1, 0);
      n = wakeCnt;
      if (k < 2)
        pulse(k);
      else
        tog();
      chk(wakeCnt - n, 1);
      mdl[1] = fl[k];
      rc(1);
      wm(1, fl[k] | en[k]);
      settle(2);
      chk(irqReq, 0);
      wm(1, fl[k] | 8'h01);
      settle(2);
      chk(irqReq, 0);
      wm(1, fl[k] | en[k] | 8'h01);
      settle(2);
      chk({irqSrc, irqReq}, {sr[k], 1'b1});
      @(posedge sys_clk);
      slow <= k[0];
      ackOn <= 1'b1;
      settle(8);
      mdl[1] = fl[k] | en[k];
      rc(1);
      ackOn <= 1'b0;
      chk(irqReq, 0);
    end
    wm(2, 0);
    pulse(2);
    mdl[2] = 8'h20;
    rc(2);
    for (g = 0; g < 2; g++)
    begin
      wm(3 + g, 8'h03);
      pulse(3 + 2 * g);
      pulse(4 + 2 * g);
      mdl[3 + g] = 8'h33;
      rc(3 + g);
      mdl[2] = mdl[2] | (g ? 8'h80 : 8'h10);
      rc(2);
      wm(3 + g, 0);
    end
    testDone();
  end
endmodule : testbench
